// >>> testbench/gdp_board.sv
// Board model on the port pins: drivers, pull-ups and floating lines
`timescale 1ns/100ps
module gdp_board (
  input wire logic mclk,
  input wire logic [7:0] pin_drv,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pull_en,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_lvl
);
  logic float_q = 1'b0;
  // Undriven line wanders so a stale value never passes for a level
  always_ff @(posedge mclk)
  begin
    float_q <= ~float_q;
  end
  // Device drive first, then board drive, then pull-up, else floating
  assign pin_lvl = (pin_oe & pin_drv) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & pull_en) | (~pin_oe & ~ext_en & ~pull_en & {8{float_q}});
endmodule // gdp_board

// >>> testbench/general_digital_io_pin_tb.sv
// Self-checking bench for the pin port
`timescale 1ns/100ps
module general_digital_io_pin_tb;
  logic mclk, rst_n, psel, penable, pwrite, pslverr, pready, sleep;
  logic [7:0] paddr, pin_i, pin_o, pin_oe, pull, flag, ext_en, ext_val;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  int mismatches, n_checks;
  gdp_port #(.N(8), .EXT_PINS(8'h03)) dut (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PIN_LEVEL(pin_i),
    .PIN_DRIVE(pin_o),
    .PIN_OE(pin_oe), .PULLUP_EN(pull), .SLEEP_DEEP(sleep), .EXT_FLAG(flag));
  gdp_board board (.mclk(mclk), .pin_drv(pin_o), .pin_oe(pin_oe), .pull_en(pull),
    .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_i));
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      mismatches++;
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task t_reset();
    chk(pin_oe, 0, "oe in reset");
    chk(pull, 0, "pull in reset");
    @(posedge mclk);
    rst_n <= 1'b1;
    apb(0, 8'h00, 0);
    chk(rd, 0, "dir reset");
    apb(0, 8'h04, 0);
    chk(rd, 0, "out reset");
  endtask
  // Tri-state to output high through pull-up input, never directly
  task t_drive();
    apb(1, 8'h04, 32'ha5);
    chk(pull, 8'ha5, "pull on inputs");
    apb(1, 8'h00, 32'hf0);
    chk(pin_oe, 8'hf0, "dir");
    chk(pin_o & pin_oe, 8'ha0, "drive");
    chk(pull, 8'h05, "no pull on outputs");
    apb(1, 8'h0c, 32'h1);
    chk(pull, 0, "global disable");
    apb(0, 8'h00, 0);
    chk(rd, 32'hf0, "dir readback");
    apb(1, 8'h0c, 32'h0);
  endtask
  task t_toggle();
    apb(1, 8'h08, 32'h81);
    chk(pin_o, 8'h24, "toggle");
    apb(0, 8'h04, 0);
    chk(rd, 32'h24, "out after toggle");
  endtask
  task t_input();
    @(posedge mclk);
    ext_val <= 8'h3c;
    repeat (3) @(posedge mclk);
    apb(0, 8'h08, 0);
    chk(rd & 32'h0f, 32'h0c, "input sync");
    apb(1, 8'h04, 32'h5a);
    apb(0, 8'h08, 0);
    chk(rd & 32'hf0, 32'h50, "written loopback");
    apb(0, 8'h1c, 0);
    chk(err, 1'b1, "unmapped error");
    chk(rd, 0, "unmapped data");
  endtask
  task t_sleep();
    apb(1, 8'h00, 0);
    apb(1, 8'h04, 0);
    ext_val <= 8'hff;
    // Falling sense on pin 0, so only the wake logic can flag its rise
    apb(1, 8'h14, 32'h2);
    apb(1, 8'h18, 32'hff);
    @(posedge mclk);
    sleep <= 1'b1;
    repeat (3) @(posedge mclk);
    apb(0, 8'h08, 0);
    chk(rd, 0, "clamped");
    apb(1, 8'h10, 32'h3);
    apb(0, 8'h08, 0);
    chk(rd, 32'h3, "clamp overridden");
    apb(1, 8'h10, 32'h0);
    apb(1, 8'h18, 32'hff);
    chk(flag[0], 1'b0, "flag cleared before wake");
    @(posedge mclk);
    sleep <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    chk(flag[0], 1'b1, "wake flag");
  endtask
  // Reset in mid-run releases the pins before any clock edge acts
  task t_rerst();
    apb(1, 8'h00, 32'hf0);
    apb(1, 8'h04, 32'h0f);
    @(posedge mclk);
    rst_n <= 1'b0;
    #1;
    chk({pin_oe, pull}, 0, "async release");
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    apb(0, 8'h04, 0);
    chk(rd, 0, "out cleared");
  endtask
  initial
  begin
    {rst_n, psel, penable, pwrite, sleep, paddr, pwdata} = '0;
    ext_en = 8'h0f;
    ext_val = 8'h00;
    repeat (20) @(posedge mclk);
    #1;
    t_reset();
    t_drive();
    t_toggle();
    t_input();
    t_sleep();
    t_rerst();
    results();
  end
  // Watchdog well past the roughly 120 cycles the tests take
  initial
  begin
    #100000;
    mismatches++;
    results();
  end
endmodule // general_digital_io_pin_tb

// >>> verilog/gdp_map.svh
// Register offsets, reset values and field positions of the pin port
`ifndef GDP_MAP_SVH
`define GDP_MAP_SVH
// Overview of operation
// R1: Direction bit one means output, zero input
// R2: Input with value one pulls up unless disabled
// R3: Reset tri-states every pin, even without clock
// R4: Output drives value bit; never pulls up
// R5: Writing one to input register toggles value
// R6: Tri-state to high passes an intermediate state
// R7: Pull-up to low passes an intermediate state
// R8: Global disable turns off all pull-ups
// R9: Synchronized level readable whatever the direction
// R10: Input path is clock-high latch then register
// R11: Pin change visible after half to 1.5 periods
// R12: Written pin value seen one period later
// R13: Software waits one cycle before reading back
// R14: Deep sleep clamps digital input to ground
// R15: No clamp on pins with interrupt enabled
// R16: Disabled edge interrupt high pin flags on wake
// R17: Software pull-up is off during reset
// R18: Software gives unused pins a defined level
// R19: Input register reads levels; others read/write
// R20: Reset clears direction and value bits
`define GDP_DIR_OFF 8'h00
`define GDP_OUT_OFF 8'h04
`define GDP_IN_OFF 8'h08
`define GDP_CTRL_OFF 8'h0c
`define GDP_IEN_OFF 8'h10
`define GDP_SENSE_OFF 8'h14
`define GDP_FLAG_OFF 8'h18
`define GDP_DIR_RST 16'h0000
`define GDP_OUT_RST 16'h0000
`define GDP_PUD_RST 1'b0
`define GDP_PUD_BIT 0
`define GDP_WAKE_DLY 3
`endif

// >>> verilog/gdp_pkg.sv
// Types shared by the pin port
package gdp_pkg;
  typedef logic [7:0] gdp_addr_t;
  typedef logic [31:0] gdp_data_t;
  // Interrupt sense per pin, two bits each in the sense register
  typedef enum logic [1:0] {
    SNS_LOW,
    SNS_ANY,
    SNS_FALL,
    SNS_RISE
  } gdp_sense_e;
endpackage

// >>> verilog/gdp_port.sv
// General digital I/O port: APB registers, pin drivers and input synchronizer
`timescale 1ns/100ps
`include "gdp_map.svh"
module gdp_port #(
  parameter int N = 8,
  parameter logic [N-1:0] EXT_PINS = {{(N-2){1'b0}}, 2'h3}
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire gdp_pkg::gdp_addr_t PADDR,
  input wire gdp_pkg::gdp_data_t PWDATA,
  input wire logic [3:0] PSTRB,
  output gdp_pkg::gdp_data_t PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [N-1:0] PIN_LEVEL,
  output logic [N-1:0] PIN_DRIVE,
  output logic [N-1:0] PIN_OE,
  output logic [N-1:0] PULLUP_EN,
  input wire logic SLEEP_DEEP,
  output logic [N-1:0] EXT_FLAG
);
  import gdp_pkg::*;

  logic [N-1:0] dir_q;
  logic [N-1:0] out_q;
  logic pud_q;
  logic [N-1:0] ien_q;
  logic [2*N-1:0] sense_q;
  logic [N-1:0] flag_q;
  logic [N-1:0] flag_set;
  logic [N-1:0] flag_clr;
  logic [N-1:0] clamp;
  logic [N-1:0] din;
  logic [N-1:0] sync_lat;
  logic [N-1:0] sync_q;
  logic [N-1:0] prev_q;
  logic sleep_prev_q;
  logic [`GDP_WAKE_DLY-1:0] wake_dly_q;
  gdp_data_t prdata_q;
  logic wr_en;
  logic setup_rd;
  logic acc;

  // Byte-lane merge of write data into an old register value
  function automatic gdp_data_t merge(input gdp_data_t old_v, input gdp_data_t new_v,
                                      input logic [3:0] strb);
    gdp_data_t r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    end
    return r;
  endfunction

  // Address decode; anything else is an error answer
  function automatic logic hit(input gdp_addr_t a);
    case (a)
      `GDP_DIR_OFF, `GDP_OUT_OFF, `GDP_IN_OFF, `GDP_CTRL_OFF,
      `GDP_IEN_OFF, `GDP_SENSE_OFF, `GDP_FLAG_OFF: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  endfunction

  // Write strobe for one offset in the access phase
  function automatic logic wr_at(input gdp_addr_t a, input gdp_addr_t off,
                                 input logic we);
    return we && (a == off);
  endfunction

  // Bus handshake; every access finishes in one access cycle
  assign acc = PSEL && PENABLE;
  assign wr_en = acc && PWRITE && hit(PADDR);
  assign setup_rd = PSEL && !PENABLE && !PWRITE;
  assign PREADY = 1'b1;
  assign PSLVERR = acc && !hit(PADDR);
  assign PRDATA = prdata_q;

  // Direction register, cleared by reset
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      dir_q <= N'(`GDP_DIR_RST); // see R20
    else if (wr_at(PADDR, `GDP_DIR_OFF, wr_en))
      dir_q <= N'(merge(gdp_data_t'(dir_q), PWDATA, PSTRB)); // see R19
  end

  // Output value: plain write, or toggle by ones written to input register
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      out_q <= N'(`GDP_OUT_RST); // see R20
    else if (wr_at(PADDR, `GDP_OUT_OFF, wr_en))
      out_q <= N'(merge(gdp_data_t'(out_q), PWDATA, PSTRB)); // see R19
    else if (wr_at(PADDR, `GDP_IN_OFF, wr_en))
      out_q <= out_q ^ N'(merge('0, PWDATA, PSTRB)); // see R5
  end

  // Global pull-up disable lives in the control register
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      pud_q <= `GDP_PUD_RST;
    else if (wr_at(PADDR, `GDP_CTRL_OFF, wr_en) && PSTRB[0])
      pud_q <= PWDATA[`GDP_PUD_BIT];
  end

  // External interrupt enables and sense modes
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      ien_q <= '0;
      sense_q <= '0;
    end
    else
    begin
      if (wr_at(PADDR, `GDP_IEN_OFF, wr_en))
        ien_q <= N'(merge(gdp_data_t'(ien_q), PWDATA, PSTRB)) & EXT_PINS;
      if (wr_at(PADDR, `GDP_SENSE_OFF, wr_en))
        sense_q <= (2*N)'(merge(gdp_data_t'(sense_q), PWDATA, PSTRB));
    end
  end

  // Read data captured in the setup cycle so PRDATA comes from a flop
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      prdata_q <= '0;
    else if (setup_rd)
    begin
      case (PADDR)
        `GDP_DIR_OFF: prdata_q <= gdp_data_t'(dir_q);
        `GDP_OUT_OFF: prdata_q <= gdp_data_t'(out_q);
        `GDP_IN_OFF: prdata_q <= gdp_data_t'(sync_q); // see R9, R19
        `GDP_CTRL_OFF: prdata_q <= gdp_data_t'(pud_q);
        `GDP_IEN_OFF: prdata_q <= gdp_data_t'(ien_q);
        `GDP_SENSE_OFF: prdata_q <= gdp_data_t'(sense_q);
        `GDP_FLAG_OFF: prdata_q <= gdp_data_t'(flag_q);
        default: prdata_q <= '0;
      endcase
    end
  end

  // Pin drivers; reset gates them at once, with or without a clock
  assign PIN_DRIVE = out_q; // see R4
  assign PIN_OE = dir_q & {N{RST_N}}; // see R1, R3
  assign PULLUP_EN = ~dir_q & out_q & {N{~pud_q & RST_N}}; // see R2, R8, R17

  // Deep-sleep clamp ahead of the input buffer, lifted for live interrupts
  assign clamp = {N{SLEEP_DEEP}} & ~(EXT_PINS & ien_q); // see R14, R15
  assign din = PIN_LEVEL & ~clamp;

  // Latch open while the clock is high; holds through the low phase
  always_latch
  begin
    if (MCLK)
      sync_lat <= din; // see R10
  end

  // Second stage: only this flop looks at the latch
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      sync_q <= '0;
    else
      sync_q <= sync_lat; // see R10, R11, R12
  end

  // Previous level for edge detection
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      prev_q <= '0;
    else
      prev_q <= sync_q;
  end

  // Wake delay lets the unclamped level settle through the synchronizer
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      sleep_prev_q <= 1'b0;
      wake_dly_q <= '0;
    end
    else
    begin
      sleep_prev_q <= SLEEP_DEEP;
      wake_dly_q <= {wake_dly_q[`GDP_WAKE_DLY-2:0], sleep_prev_q & ~SLEEP_DEEP};
    end
  end

  // Flag events per pin from the sense mode
  always_comb
  begin
    flag_set = '0;
    for (int i = 0; i < N; i++)
    begin
      case (gdp_sense_e'(sense_q[2*i +: 2]))
        SNS_LOW: flag_set[i] = !sync_q[i];
        SNS_ANY: flag_set[i] = sync_q[i] ^ prev_q[i];
        SNS_FALL: flag_set[i] = prev_q[i] && !sync_q[i];
        SNS_RISE: flag_set[i] = !prev_q[i] && sync_q[i];
        default: flag_set[i] = 1'b0;
      endcase
      // Clamp hides the edge; a high disabled pin with a sense mode other than SNS_LOW still flags on wake
      if (wake_dly_q[`GDP_WAKE_DLY-1] && sync_q[i] && !ien_q[i]
          && (sense_q[2*i +: 2] != 2'h0))
        flag_set[i] = 1'b1; // see R16
    end
    flag_set = flag_set & EXT_PINS;
  end

  // Write-one-to-clear; a new event in the same cycle wins
  assign flag_clr = wr_at(PADDR, `GDP_FLAG_OFF, wr_en) ?
                    N'(merge('0, PWDATA, PSTRB)) : '0;

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      flag_q <= '0;
    else
      flag_q <= (flag_q & ~flag_clr) | flag_set;
  end

  assign EXT_FLAG = flag_q;

  // Checks
  sequence s_wr_dir;
    PSEL && PENABLE && PWRITE && PADDR == `GDP_DIR_OFF && PSTRB[0];
  endsequence

  sequence s_wr_tog;
    PSEL && PENABLE && PWRITE && PADDR == `GDP_IN_OFF && PSTRB[0];
  endsequence

  sequence s_rd_in;
    PSEL && !PENABLE && !PWRITE && PADDR == `GDP_IN_OFF;
  endsequence

  property p_dir_drives;
    @(posedge MCLK) disable iff (!RST_N)
    s_wr_dir |=> PIN_OE[7:0] == $past(PWDATA[7:0]);
  endproperty
  a_dir_drives: assert property (p_dir_drives) // see R1
    else $error("direction write did not set output enables");

  property p_pullup;
    @(posedge MCLK) disable iff (!RST_N)
    PULLUP_EN == (~dir_q & out_q & {N{~pud_q}});
  endproperty
  a_pullup: assert property (p_pullup) // see R2
    else $error("pull-up enable does not match direction and value");

  property p_reset_tristate;
    @(posedge MCLK)
    !RST_N |-> PIN_OE == '0 && PULLUP_EN == '0;
  endproperty
  a_reset_tristate: assert property (p_reset_tristate) // see R3
    else $error("pin driven or pulled during reset");

  property p_out_value;
    @(posedge MCLK) disable iff (!RST_N)
    PIN_OE[0] |-> PIN_DRIVE[0] == out_q[0] && !PULLUP_EN[0];
  endproperty
  a_out_value: assert property (p_out_value) // see R4
    else $error("output pin value wrong or pulled up");

  property p_toggle;
    @(posedge MCLK) disable iff (!RST_N)
    s_wr_tog |=> PIN_DRIVE[7:0] == ($past(PIN_DRIVE[7:0]) ^ $past(PWDATA[7:0]));
  endproperty
  a_toggle: assert property (p_toggle) // see R5
    else $error("toggle write did not invert the value bits");

  property p_pud_off;
    @(posedge MCLK) disable iff (!RST_N)
    pud_q |-> PULLUP_EN == '0;
  endproperty
  a_pud_off: assert property (p_pud_off) // see R8
    else $error("pull-up on while globally disabled");

  property p_read_in;
    @(posedge MCLK) disable iff (!RST_N)
    s_rd_in |=> PRDATA[N-1:0] == $past(sync_q);
  endproperty
  a_read_in: assert property (p_read_in) // see R9
    else $error("input register read not the synchronized level");

  property p_sync_lag;
    @(posedge MCLK) disable iff (!RST_N)
    $stable(PIN_LEVEL) && !SLEEP_DEEP ##1 $stable(PIN_LEVEL) && !SLEEP_DEEP
      |=> sync_q == $past(PIN_LEVEL);
  endproperty
  a_sync_lag: assert property (p_sync_lag) // see R11
    else $error("steady pin level not seen within two edges");

  property p_clamp;
    @(posedge MCLK) disable iff (!RST_N)
    SLEEP_DEEP && !ien_q[0] |-> !din[0];
  endproperty
  a_clamp: assert property (p_clamp) // see R14
    else $error("input not clamped in deep sleep");

  property p_wake_flag;
    @(posedge MCLK) disable iff (!RST_N)
    wake_dly_q[`GDP_WAKE_DLY-1] && EXT_PINS[0] && sync_q[0] && !ien_q[0]
      && sense_q[1:0] != 2'h0 |=> flag_q[0];
  endproperty
  a_wake_flag: assert property (p_wake_flag) // see R16
    else $error("wake with high pin did not set the flag");

  property p_reset_clear;
    @(posedge MCLK)
    !RST_N |=> dir_q == '0 && out_q == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) // see R20
    else $error("reset did not clear direction and value");

  // Outputs never carry a pull-up as well
  property p_no_pull_out;
    @(posedge MCLK) disable iff (!RST_N)
    (PIN_OE & PULLUP_EN) == '0;
  endproperty
  a_no_pull_out: assert property (p_no_pull_out) // see R4
    else $error("pull-up enabled on a driven pin");

  // Live interrupt pins keep their input through deep sleep
  property p_clamp_lift;
    @(posedge MCLK) disable iff (!RST_N)
    SLEEP_DEEP && EXT_PINS[0] && ien_q[0] |-> din[0] == PIN_LEVEL[0];
  endproperty
  a_clamp_lift: assert property (p_clamp_lift) // see R15
    else $error("clamp applied to an enabled interrupt pin");

  // Toggle writes touch only the value bits, nothing is stored
  property p_in_no_store;
    @(posedge MCLK) disable iff (!RST_N)
    s_wr_tog |=> $stable(dir_q) && $stable(pud_q);
  endproperty
  a_in_no_store: assert property (p_in_no_store) // see R19
    else $error("input register write changed another register");

endmodule // gdp_port
